// ---- pkg/adc_conv_regs.vh ----
// register offsets, field positions, reset values and mode codes
// for the converter sequencer; definitions only
`ifndef ADC_CONV_REGS_VH
`define ADC_CONV_REGS_VH

// byte offsets on the register bus
`define OFF_CONTROL      8'h00
`define OFF_CONFIG       8'h04
`define OFF_DECIM        8'h08
`define OFF_MODE         8'h0c
`define OFF_STATUS       8'h10
`define OFF_MASK         8'h14
`define OFF_SINC3_HIGH   8'h18
`define OFF_SINC3_MID    8'h1c
`define OFF_SINC3_LOW    8'h20
`define OFF_FAST_HIGH    8'h24
`define OFF_FAST_MID     8'h28
`define OFF_FAST_LOW     8'h2c

// control register fields
`define CTRL_POL_BIT     4
`define CTRL_BURN_BIT    3
`define CTRL_GAIN_MSB    2
`define CTRL_RESET       8'h10

// config register fields
`define CFG_SEL_BIT      0
`define CFG_RESET        8'h00

// mode register fields and codes
`define MODE_BUSY_BIT    4
`define MODE_IDLE        2'h0
`define MODE_SINGLE      2'h1
`define MODE_CONT        2'h2

// status and mask bits
`define ST_DONE_BIT      0
`define ST_FAST_BIT      1
`define ST_SINC3_BIT     2
`define ST_WIDTH         3

// decimation ratio reset value
`define DECIM_RESET      16'h0100

`endif

// ---- design/mod_clock_gen.v ----
// modulator clock divider: drives the modulator clock pin and a
// one-cycle sample tick; assumes core_clk and arst_n of the top
`timescale 1ns/1ps
`default_nettype none

module mod_clock_gen
#(
  parameter DIV = 8
)
(
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // modulator timing
  output reg         mod_clk,
  output reg         sample_tick
);

  reg [15:0] div_cnt_reg;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_reg <= 16'h0000;
      mod_clk     <= 1'b0;
      sample_tick <= 1'b0;
    end
    else
    begin
      if (div_cnt_reg == DIV[15:0] - 16'h0001)
        div_cnt_reg <= 16'h0000;
      else
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      mod_clk     <= (div_cnt_reg < DIV[15:1]);
      sample_tick <= (div_cnt_reg == DIV[15:0] - 16'h0001);
    end
  end

endmodule // mod_clock_gen

`default_nettype wire

// ---- design/result_format.v ----
// output word formatting: straight binary or two's complement
// around half of full scale; purely combinational
`timescale 1ns/1ps
`default_nettype none

module result_format
(
  // raw filter sum and its full scale
  input  wire [23:0] raw,
  input  wire [23:0] full_scale,
  input  wire        bipolar,
  // formatted word
  output wire [23:0] word
);

  assign word = bipolar ? (raw - {1'b0, full_scale[23:1]}) : raw;

endmodule // result_format

`default_nettype wire

// ---- design/adc_conv_ctrl.v ----
// conversion sequencer for a delta-sigma converter with a sinc3 and a
// fast filter, register file on an ahb-lite slave port
// assumes one clock, a modulator bit stream on a pin and one bus master
//
// Overview of operation
// R1: writing single mode starts one conversion sized for the selected filter
// R2: busy flag stays 1 while single or continuous conversions run
// R3: fast result after one conversion cycle, sinc3 after three
// R4: done flag set on fast result if select is 1, else on sinc3
// R5: single mode returns to idle and clears busy when selected filter finishes
// R6: sinc3-targeted single conversion also yields a valid fast result
// R7: continuous mode restarts each conversion right after the previous one
// R8: continuous: fast every cycle, sinc3 first after three then every cycle
// R9: continuous mode updates both result sets regardless of select
// R10: software ends continuous mode by writing idle mode
// R11: conversion cycle length is modulator clock times decimation ratio
// R12: sinc3 and fast results held in separate high, mid, low registers
// R13: polarity bit selects unipolar or bipolar output words
// R14: sinc3 uses last three cycles, fast uses current cycle only
// R15: software should keep burnout sources off during normal measurements
// R16: control register writes accepted only while in idle mode
// R17: done flag stays set until software clears it
// R18: the three bytes of a result update together
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_regs.vh"

module adc_conv_ctrl
#(
  parameter MOD_DIV = 8
)
(
  // clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // modulator side
  output wire        mod_clk,
  input  wire        mod_data,
  output wire        burnout_en,
  output wire [2:0]  pga_gain,
  // interrupt
  output wire        irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus slave

  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [7:0]  addr_q_reg;
  wire       take_ap;
  wire       wr_now;

  assign take_ap   = hsel & htrans[1] & hready;
  assign wr_now    = wr_pend_reg;
  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'b0;

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_q_reg  <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take_ap & hwrite;
      rd_pend_reg <= take_ap & ~hwrite;
      if (take_ap)
        addr_q_reg <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]  ctrl_reg;
  reg  [7:0]  cfg_reg;
  reg  [15:0] decim_reg;
  reg  [1:0]  mode_reg;
  reg  [1:0]  mode_next;
  reg         state_reg;
  reg         state_next;
  reg  [2:0]  status_reg;
  reg  [2:0]  status_mask_reg;
  reg  [23:0] sinc3_res_reg;
  reg  [23:0] fast_res_reg;

  wire        sel_fast;
  wire        mode_wr;
  wire        idle_now;
  wire [2:0]  st_set;
  wire [2:0]  st_clr;

  assign sel_fast   = cfg_reg[`CFG_SEL_BIT];
  assign mode_wr    = wr_now & hit(addr_q_reg, `OFF_MODE);
  assign idle_now   = (mode_reg == `MODE_IDLE);
  assign burnout_en = ctrl_reg[`CTRL_BURN_BIT];
  assign pga_gain   = ctrl_reg[`CTRL_GAIN_MSB:0];

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg        <= `CTRL_RESET;
      cfg_reg         <= `CFG_RESET;
      decim_reg       <= `DECIM_RESET;
      status_mask_reg <= 3'h0;
    end
    else if (wr_now)
    begin
      if (hit(addr_q_reg, `OFF_CONTROL) && idle_now)  // see R16
        ctrl_reg <= {3'h0, hwdata[4:0]};
      if (hit(addr_q_reg, `OFF_CONFIG))
        cfg_reg <= {7'h00, hwdata[`CFG_SEL_BIT]};
      if (hit(addr_q_reg, `OFF_DECIM) && idle_now)
        decim_reg <= hwdata[15:0];
      if (hit(addr_q_reg, `OFF_MASK))
        status_mask_reg <= hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // modulator clock and input synchroniser

  wire mod_tick;
  reg  mod_sync1_reg;
  reg  mod_sync2_reg;

  mod_clock_gen
  #(
    .DIV (MOD_DIV)
  )
  u_mod_clock
  (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .mod_clk     (mod_clk),
    .sample_tick (mod_tick)
  );

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mod_sync1_reg <= 1'b0;
      mod_sync2_reg <= 1'b0;
    end
    else
    begin
      mod_sync1_reg <= mod_data;
      mod_sync2_reg <= mod_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // conversion cycle counting and filter sums

  reg  [15:0] pos_reg;
  reg  [23:0] ones_reg;
  reg  [23:0] hist1_reg;
  reg  [23:0] hist2_reg;
  reg  [1:0]  periods_reg;

  wire [15:0] cycle_last;
  wire        cycle_end;
  wire [23:0] ones_now;
  wire [23:0] sinc3_raw;
  wire [23:0] fast_full;
  wire [23:0] sinc3_full;
  wire        fast_upd;
  wire        sinc3_upd;
  wire        done_evt;
  wire        start;
  wire [23:0] fast_word;
  wire [23:0] sinc3_word;

  assign cycle_last = (decim_reg == 16'h0000) ? 16'h0000 : decim_reg - 16'h0001;
  assign cycle_end  = (state_reg == ST_RUN) & mod_tick
                      & (pos_reg == cycle_last);  // see R11
  assign ones_now   = ones_reg + {23'h000000, mod_sync2_reg};
  assign sinc3_raw  = ones_now + hist1_reg + hist2_reg;  // see R14
  assign fast_full  = {8'h00, cycle_last} + 24'h000001;
  assign sinc3_full = fast_full + fast_full + fast_full;
  assign fast_upd   = cycle_end;  // see R3
  assign sinc3_upd  = cycle_end & (periods_reg == 2'h2)
                      & ((mode_reg == `MODE_CONT) | ~sel_fast);  // see R8
  assign done_evt   = sel_fast ? fast_upd : sinc3_upd;  // see R4
  assign start      = mode_wr & (hwdata[1:0] == `MODE_SINGLE
                                 || hwdata[1:0] == `MODE_CONT);

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_reg     <= 16'h0000;
      ones_reg    <= 24'h000000;
      hist1_reg   <= 24'h000000;
      hist2_reg   <= 24'h000000;
      periods_reg <= 2'h0;
    end
    else if (start)
    begin
      pos_reg     <= 16'h0000;
      ones_reg    <= 24'h000000;
      hist1_reg   <= 24'h000000;
      hist2_reg   <= 24'h000000;
      periods_reg <= 2'h0;
    end
    else if (state_reg == ST_RUN && mod_tick)
    begin
      if (cycle_end)
      begin
        pos_reg   <= 16'h0000;
        ones_reg  <= 24'h000000;
        hist1_reg <= ones_now;  // see R14
        hist2_reg <= hist1_reg;
        if (periods_reg != 2'h2)
          periods_reg <= periods_reg + 2'h1;
      end
      else
      begin
        pos_reg  <= pos_reg + 16'h0001;
        ones_reg <= ones_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output formatting and result registers

  result_format u_fast_fmt
  (
    .raw        (ones_now),
    .full_scale (fast_full),
    .bipolar    (ctrl_reg[`CTRL_POL_BIT]),
    .word       (fast_word)
  );

  result_format u_sinc3_fmt
  (
    .raw        (sinc3_raw),
    .full_scale (sinc3_full),
    .bipolar    (ctrl_reg[`CTRL_POL_BIT]),
    .word       (sinc3_word)
  );

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fast_res_reg  <= 24'h000000;
      sinc3_res_reg <= 24'h000000;
    end
    else
    begin
      if (fast_upd)  // see R6 see R9 see R12 see R13
        fast_res_reg <= fast_word;  // see R18
      if (sinc3_upd)  // see R9 see R12 see R13
        sinc3_res_reg <= sinc3_word;  // see R18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer

  always @*
  begin
    mode_next  = mode_reg;
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start)  // see R1 see R7
        begin
          mode_next  = hwdata[1:0];
          state_next = ST_RUN;
        end
        else if (mode_wr)
          mode_next = `MODE_IDLE;
      end
      ST_RUN:
      begin
        if (mode_wr)
        begin
          if (start)
            mode_next = hwdata[1:0];
          else
          begin
            mode_next  = `MODE_IDLE;  // see R10
            state_next = ST_IDLE;
          end
        end
        else if (mode_reg == `MODE_SINGLE && done_evt)
        begin
          mode_next  = `MODE_IDLE;  // see R5
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        mode_next  = `MODE_IDLE;
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg  <= `MODE_IDLE;
      state_reg <= ST_IDLE;
    end
    else
    begin
      mode_reg  <= mode_next;
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins

  assign st_set[`ST_DONE_BIT]  = done_evt;
  assign st_set[`ST_FAST_BIT]  = fast_upd;
  assign st_set[`ST_SINC3_BIT] = sinc3_upd;
  assign st_clr = (wr_now && hit(addr_q_reg, `OFF_STATUS)) ? hwdata[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `ST_WIDTH; gi = gi + 1)
    begin : g_status
      always @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          status_reg[gi] <= 1'b0;
        else if (st_set[gi])  // see R17
          status_reg[gi] <= 1'b1;
        else if (st_clr[gi])
          status_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(status_reg & status_mask_reg);

  ////////////////////////////////////////////////////////////////////
  // read data

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h00000000;
    if (hit(addr_q_reg, `OFF_CONTROL))
      rd_mux = {24'h000000, ctrl_reg};
    else if (hit(addr_q_reg, `OFF_CONFIG))
      rd_mux = {24'h000000, cfg_reg};
    else if (hit(addr_q_reg, `OFF_DECIM))
      rd_mux = {16'h0000, decim_reg};
    else if (hit(addr_q_reg, `OFF_MODE))
      rd_mux = {27'h0000000, ~idle_now, 2'h0, mode_reg};  // see R2
    else if (hit(addr_q_reg, `OFF_STATUS))
      rd_mux = {29'h00000000, status_reg};
    else if (hit(addr_q_reg, `OFF_MASK))
      rd_mux = {29'h00000000, status_mask_reg};
    else if (hit(addr_q_reg, `OFF_SINC3_HIGH))
      rd_mux = {24'h000000, sinc3_res_reg[23:16]};
    else if (hit(addr_q_reg, `OFF_SINC3_MID))
      rd_mux = {24'h000000, sinc3_res_reg[15:8]};
    else if (hit(addr_q_reg, `OFF_SINC3_LOW))
      rd_mux = {24'h000000, sinc3_res_reg[7:0]};
    else if (hit(addr_q_reg, `OFF_FAST_HIGH))
      rd_mux = {24'h000000, fast_res_reg[23:16]};
    else if (hit(addr_q_reg, `OFF_FAST_MID))
      rd_mux = {24'h000000, fast_res_reg[15:8]};
    else if (hit(addr_q_reg, `OFF_FAST_LOW))
      rd_mux = {24'h000000, fast_res_reg[7:0]};
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      hrdata <= 32'h00000000;
    else if (rd_pend_reg)
      hrdata <= rd_mux;
  end

endmodule // adc_conv_ctrl

`default_nettype wire

// ---- tb/adc_conv_ctrl_asserts.sv ----
// port checker for the converter sequencer
// assumes hready is tied to hreadyout and a single bus master
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctrl_asserts
#(
  parameter MOD_DIV = 8
)
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // converter side
  input wire logic        mod_clk,
  input wire logic        burnout_en,
  input wire logic [2:0]  pga_gain,
  input wire logic        irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  wire       take = hsel & htrans[1] & hready;
  logic      rd_dp;
  logic      wr_dp;
  logic      ctl_dp;
  logic      mseen;
  logic [7:0] mcnt;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      ctl_dp <= 1'b0;
      mseen <= 1'b0;
      mcnt <= 8'h0;
    end
    else
    begin
      rd_dp <= take & !hwrite;
      wr_dp <= take & hwrite;
      ctl_dp <= take & hwrite & (haddr[7:2] == 6'h0);
      mseen <= mseen | $rose(mod_clk);
      mcnt <= $rose(mod_clk) ? 8'h0 : mcnt + 8'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_ready_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  chk_mod_period: assert property ($rose(mod_clk) && mseen |-> mcnt == MOD_DIV - 1)
    else $error("modulator clock period wrong");
  chk_ctl_write: assert property ($changed({burnout_en, pga_gain}) |-> $past(ctl_dp))
    else $error("control outputs changed without a write");
  chk_irq_hold: assert property ($fell(irq) |-> $past(wr_dp))
    else $error("interrupt dropped without a write");
  chk_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_dp) || rd_dp)
    else $error("read data changed outside a read");
endmodule // adc_conv_ctrl_asserts
bind adc_conv_ctrl adc_conv_ctrl_asserts #(.MOD_DIV(MOD_DIV)) u_chk (.core_clk, .arst_n,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .mod_clk,
  .burnout_en, .pga_gain, .irq);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the converter sequencer
// assumes the design files and the register header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_regs.vh"
module tb_top;
  localparam int MD = 4;
  localparam int DEC = 4;
  localparam int CYC = MD * DEC;
  logic        core_clk;
  logic        arst_n;
  logic        hsel;
  logic        hwrite;
  logic        mod_data;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rv;
  logic [7:0]  lf;
  wire logic [31:0] hrdata;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic        hready;
  wire logic        mod_clk;
  wire logic        burnout_en;
  wire logic        irq;
  wire logic [2:0]  pga_gain;
  int          err_count;
  int          n_compared;
  int          cq[$];
  assign hready = hreadyout;
  adc_conv_ctrl #(.MOD_DIV(MD)) DUT (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hwdata, .hrdata, .hreadyout, .hresp, .mod_clk, .mod_data, .burnout_en,
    .pga_gain, .irq);
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(input logic [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rv = hrdata;
    chk(rv, e);
  endtask
  task wirq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 500)
    begin
      @(posedge core_clk);
      i++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  function automatic int mdl(input int n, input int full, input logic pol);
    int s;
    s = 0;
    for (int i = 0; i < n; i++) s += cq[cq.size() - 1 - i];
    return pol ? s - full / 2 : s;
  endfunction
  task res(input logic [7:0] b, input int v);
    for (int i = 0; i < 3; i++) rc(b + 8'(4 * i), 32'((v >> (16 - 8 * i)) & 255));
  endtask
  ////////////////////////////////////////////////////////////
  task conv(input logic sel, input logic pol);
    int t;
    int e;
    int b;
    lf = nxt(lf);
    b = lf[0];
    mod_data <= lf[0];
    wr(`OFF_CONTROL, {27'h0, pol, 4'h0});
    wr(`OFF_CONFIG, {31'h0, sel});
    wr(`OFF_MASK, 32'h1);
    wr(`OFF_MODE, 32'h1);
    t = $time;
    rc(`OFF_MODE, 32'h11);
    wr(`OFF_CONTROL, 32'h7);
    wirq;
    t = ($time - t) / 8;
    e = sel ? CYC : 3 * CYC;
    chk(32'(t >= e - MD && t <= e + 16), 32'h1);
    rc(`OFF_MODE, 32'h0);
    rc(`OFF_CONTROL, {27'h0, pol, 4'h0});
    chk({29'h0, pga_gain}, 32'h0);
    cq.delete();
    repeat (sel ? 1 : 3) cq.push_back(b * DEC);
    res(`OFF_FAST_HIGH, mdl(1, DEC, pol));
    if (!sel) res(`OFF_SINC3_HIGH, mdl(3, 3 * DEC, pol));
    rc(`OFF_STATUS, sel ? 32'h3 : 32'h7);
    wr(`OFF_STATUS, 32'h7);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("single conversion sel %0d pol %0d done", sel, pol);
  endtask
  task cont;
    int t;
    int b;
    lf = nxt(lf);
    b = lf[0];
    mod_data <= lf[0];
    cq.delete();
    wr(`OFF_CONTROL, 32'h0);
    wr(`OFF_CONFIG, 32'h1);
    wr(`OFF_MODE, 32'h2);
    wirq;
    t = $time;
    cq.push_back(b * DEC);
    rc(`OFF_STATUS, 32'h3);
    for (int k = 0; k < 3; k++)
    begin
      wr(`OFF_STATUS, 32'h7);
      @(posedge core_clk);
      wirq;
      chk(32'(($time - t) / 8), CYC);
      t = $time;
      cq.push_back(b * DEC);
    end
    rc(`OFF_STATUS, 32'h7);
    rc(`OFF_MODE, 32'h12);
    res(`OFF_SINC3_HIGH, mdl(3, 3 * DEC, 1'b0));
    res(`OFF_FAST_HIGH, mdl(1, DEC, 1'b0));
    wr(`OFF_MODE, 32'h0);
    rc(`OFF_MODE, 32'h0);
    wr(`OFF_MASK, 32'h0);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`OFF_MASK, 32'h1);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_STATUS, 32'h7);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`OFF_MODE, 32'h1);
    wr(`OFF_MODE, 32'h3);
    rc(`OFF_MODE, 32'h0);
    repeat (2 * CYC) @(posedge core_clk);
    rc(`OFF_STATUS, 32'h0);
    $display("continuous conversion done");
  endtask
  ////////////////////////////////////////////////////////////
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    end_sim;
  end
  initial
  begin
    arst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    mod_data = 1'b0;
    err_count = 0;
    n_compared = 0;
    lf = 8'he4;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rc(`OFF_CONTROL, 32'h10);
    rc(`OFF_CONFIG, 32'h0);
    rc(`OFF_DECIM, 32'h100);
    rc(`OFF_MODE, 32'h0);
    rc(`OFF_STATUS, 32'h0);
    wr(8'h30, 32'hffffffff);
    rc(8'h30, 32'h0);
    $display("reset values done");
    lf = nxt(lf);
    wr(`OFF_CONTROL, {27'h0, lf[4:0]});
    @(posedge core_clk);
    chk({28'h0, burnout_en, pga_gain}, {28'h0, lf[3:0]});
    rc(`OFF_CONTROL, {27'h0, lf[4:0]});
    wr(`OFF_DECIM, DEC);
    rc(`OFF_DECIM, DEC);
    $display("control and ratio done");
    for (int s = 0; s < 4; s++) conv(s[1], s[0]);
    cont;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
